// file: rtl/tfs_consts.svh
// constants for the thermal and fan status register bank
`ifndef TFS_CONSTS_SVH
`define TFS_CONSTS_SVH

// register indices; byte address is four times the index
`define TFS_IDX_THERMAL 10'h050
`define TFS_IDX_FAN 10'h051
`define TFS_IDX_LIMIT 10'h052
`define TFS_IDX_CTRL 10'h053
`define TFS_IDX_ONTIME 10'h054

// thermal status field positions
`define TFS_TH_LOCAL 7
`define TFS_TH_REMOTE1 6
`define TFS_TH_REMOTE2 5
`define TFS_TH_DUTY 4
`define TFS_TH_INPUT 3
`define TFS_TH_DRIVEN 2

// fan status field positions
`define TFS_FAN_STALL1 7
`define TFS_FAN_ALARM 6
`define TFS_FAN_STALL2 5
`define TFS_FAN_ALERT 0

// control register field positions
`define TFS_CTRL_SWRST 0
`define TFS_CTRL_FORCE 1

// reset values
`define TFS_STATUS_RST 8'h00
`define TFS_LIMIT_RST 8'h00
`define TFS_CTRL_RST 8'h00
`define TFS_ONTIME_RST 8'h00

// duty window timing: 256 slots, one sample in each of the first 255
`define TFS_CLK_PERIOD_NS 8
`define TFS_SLOT_NS 1000
`define TFS_SLOT_CYC (`TFS_SLOT_NS / `TFS_CLK_PERIOD_NS)
`define TFS_WIN_SLOTS 256

`endif

// file: rtl/tfs_duty_meter.sv
// measures overtemp pin on-time over a window and flags duty excess
`timescale 1ns/1ps
`include "tfs_consts.svh"

module tfs_duty_meter #(
   parameter int SLOT_CYC = `TFS_SLOT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic active,
   input wire logic [7:0] limit,
   output logic exceed,
   output logic [7:0] onTime
);

   logic [15:0] slotCnt_q;
   logic [7:0] slotIdx_q;
   logic [8:0] onAcc_q;
   logic slotEnd;

   assign slotEnd = (slotCnt_q == 16'(SLOT_CYC - 1));

   always_ff @(posedge clk) begin
      if (sys_rst || clr || slotEnd) begin
         slotCnt_q <= 16'h0000;
      end else begin
         slotCnt_q <= slotCnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || clr) begin
         slotIdx_q <= 8'h00;
         onAcc_q <= 9'h000;
         onTime <= `TFS_ONTIME_RST;
      end else if (slotEnd) begin
         slotIdx_q <= slotIdx_q + 8'h01;
         if (slotIdx_q == 8'(`TFS_WIN_SLOTS - 1)) begin
            onTime <= onAcc_q[8] ? 8'hFF : onAcc_q[7:0];
            onAcc_q <= 9'h000;
         end else if (active) begin
            onAcc_q <= onAcc_q + 9'h001;
         end
      end
   end

   // pulse when on-time first passes the limit; zero limit flags at once
   always_ff @(posedge clk) begin
      if (sys_rst || clr) begin
         exceed <= 1'b0;
      end else begin
         exceed <= (active && limit == 8'h00) ||
                   (active && slotEnd && onAcc_q == {1'b0, limit});
      end
   end

endmodule : tfs_duty_meter

// file: rtl/tfs_pkg.sv
// types shared by the thermal and fan status register bank
package tfs_pkg;

   typedef struct packed {
      logic localTrip;
      logic remote1Trip;
      logic remote2Trip;
   } tfs_trip_t;

   typedef struct packed {
      logic fan1Stall;
      logic fan2Stall;
      logic alarmSpeed;
      logic alertLow;
   } tfs_fan_t;

   typedef enum logic [1:0] {
      TFS_IDLE = 2'b01,
      TFS_ANSWER = 2'b10
   } tfs_apb_state_t;

endpackage : tfs_pkg

// file: rtl/tfs_status_regs.sv
// thermal and fan status register bank with an APB slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "tfs_consts.svh"

// Contract
// - thermal status bit 7 shows the local overtemp limit tripped
// - thermal status bit 6 shows the first remote overtemp limit tripped
// - thermal status bit 5 shows the second remote overtemp limit tripped
// - bit 4 sets on pin duty over limit; a read clears it
// - zero duty limit with pin asserted sets bit 4 again at once
// - bit 3 shows the pin pulled low externally, used as input
// - bit 2 shows the device itself driving the pin low
// - fan status bit 7 shows the first fan stalled
// - fan status bit 6 shows fans forced to full speed by alarm
// - fan status bit 5 shows the second fan stalled
// - fan status bit 0 shows the alert output driven low
// - both status registers clear at power-on and on software reset
module tfs_status_regs #(
   parameter int ADDR_W = 12,
   parameter int SLOT_CYC = `TFS_SLOT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire tfs_pkg::tfs_trip_t trips,
   input wire tfs_pkg::tfs_fan_t fanState,
   input wire logic overtempDriveReq,
   input wire logic overtempPinIn,
   output logic overtempPinOut,
   output logic overtempPinOe
);

   ////////////////////////////////////////////////////////////////////
   // declarations

   tfs_pkg::tfs_apb_state_t state_q;
   logic [7:0] thermalStatus_q;
   logic [7:0] fanAlertStatus_q;
   logic [7:0] overtempDutyLimit_q;
   logic overtempForce_q;
   logic swReset_q;
   logic pinMeta_q;
   logic pinSync_q;
   logic [1:0] oeHist_q;
   logic overtempActive;
   logic overtempDutyExceeded;
   logic [7:0] onTime;
   logic accessDone;
   logic rdThermal;
   logic [9:0] regIdx;
   logic idxMapped;
   logic wrDone;
   logic [31:0] rdData;

   ////////////////////////////////////////////////////////////////////
   // bus decode

   assign regIdx = paddr[11:2];
   assign idxMapped = (paddr[1:0] == 2'b00) &&
                      (regIdx == `TFS_IDX_THERMAL || regIdx == `TFS_IDX_FAN ||
                       regIdx == `TFS_IDX_LIMIT || regIdx == `TFS_IDX_CTRL ||
                       regIdx == `TFS_IDX_ONTIME);
   // edge at which the master samples pready high
   assign accessDone = psel && penable && pready;
   assign wrDone = accessDone && pwrite && idxMapped;
   assign rdThermal = accessDone && !pwrite &&
                      paddr[1:0] == 2'b00 && regIdx == `TFS_IDX_THERMAL;

   always_comb begin
      rdData = 32'h0000_0000;
      if (paddr[1:0] == 2'b00) begin
         unique case (regIdx)
            `TFS_IDX_THERMAL: rdData = {24'h00_0000, thermalStatus_q};
            `TFS_IDX_FAN: rdData = {24'h00_0000, fanAlertStatus_q};
            `TFS_IDX_LIMIT: rdData = {24'h00_0000, overtempDutyLimit_q};
            `TFS_IDX_CTRL: rdData = {30'h0000_0000, overtempForce_q, 1'b0};
            `TFS_IDX_ONTIME: rdData = {24'h00_0000, onTime};
            default: rdData = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, then pready with data

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= tfs_pkg::TFS_IDLE;
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         unique case (state_q)
            tfs_pkg::TFS_IDLE: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               if (psel && penable) begin
                  state_q <= tfs_pkg::TFS_ANSWER;
                  pready <= 1'b1;
                  prdata <= pwrite ? 32'h0000_0000 : rdData;
                  pslverr <= !idxMapped;
               end
            end
            tfs_pkg::TFS_ANSWER: begin
               state_q <= tfs_pkg::TFS_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overtempDutyLimit_q <= `TFS_LIMIT_RST;
      end else if (swReset_q) begin
         overtempDutyLimit_q <= `TFS_LIMIT_RST;
      end else if (wrDone && regIdx == `TFS_IDX_LIMIT && pstrb[0]) begin
         overtempDutyLimit_q <= pwdata[7:0];
      end
   end

   // software reset bit clears itself after one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         swReset_q <= 1'b0;
         overtempForce_q <= 1'b0;
      end else if (wrDone && regIdx == `TFS_IDX_CTRL && pstrb[0]) begin
         swReset_q <= pwdata[`TFS_CTRL_SWRST];
         overtempForce_q <= pwdata[`TFS_CTRL_FORCE];
      end else begin
         swReset_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // overtemp pin: open drain, sampled through two flops

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinMeta_q <= 1'b1;
         pinSync_q <= 1'b1;
      end else begin
         pinMeta_q <= overtempPinIn;
         pinSync_q <= pinMeta_q;
      end
   end

   assign overtempActive = !pinSync_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overtempPinOut <= 1'b0;
         overtempPinOe <= 1'b0;
      end else begin
         overtempPinOut <= 1'b0;
         overtempPinOe <= overtempDriveReq || overtempForce_q;
      end
   end

   // drive history lined up with the two sync flops on the readback
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oeHist_q <= 2'b00;
      end else begin
         oeHist_q <= {oeHist_q[0], overtempPinOe};
      end
   end

   tfs_duty_meter #(
      .SLOT_CYC(SLOT_CYC)
   ) u_duty (
      .clk(clk),
      .sys_rst(sys_rst),
      .clr(swReset_q),
      .active(overtempActive),
      .limit(overtempDutyLimit_q),
      .exceed(overtempDutyExceeded),
      .onTime(onTime)
   );

   ////////////////////////////////////////////////////////////////////
   // thermal status

   always_ff @(posedge clk) begin
      if (sys_rst || swReset_q) begin
         thermalStatus_q <= `TFS_STATUS_RST;
      end else begin
         thermalStatus_q[`TFS_TH_LOCAL] <= trips.localTrip;
         thermalStatus_q[`TFS_TH_REMOTE1] <= trips.remote1Trip;
         thermalStatus_q[`TFS_TH_REMOTE2] <= trips.remote2Trip;
         // sticky; a new excess beats the clear of a read
         if (overtempDutyExceeded) begin
            thermalStatus_q[`TFS_TH_DUTY] <= 1'b1;
         end else if (rdThermal) begin
            thermalStatus_q[`TFS_TH_DUTY] <= 1'b0;
         end
         // readback lags the drive; a pin we just released is not an external pull
         thermalStatus_q[`TFS_TH_INPUT] <= overtempActive && !overtempPinOe &&
                                           oeHist_q == 2'b00;
         thermalStatus_q[`TFS_TH_DRIVEN] <= overtempPinOe;
         thermalStatus_q[1:0] <= 2'b00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fan and alert status

   always_ff @(posedge clk) begin
      if (sys_rst || swReset_q) begin
         fanAlertStatus_q <= `TFS_STATUS_RST;
      end else begin
         fanAlertStatus_q[`TFS_FAN_STALL1] <= fanState.fan1Stall;
         fanAlertStatus_q[`TFS_FAN_ALARM] <= fanState.alarmSpeed;
         fanAlertStatus_q[`TFS_FAN_STALL2] <= fanState.fan2Stall;
         fanAlertStatus_q[`TFS_FAN_ALERT] <= fanState.alertLow;
         fanAlertStatus_q[4:1] <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_local_trip;
      !swReset_q |=> thermalStatus_q[`TFS_TH_LOCAL] == $past(trips.localTrip);
   endproperty
   a_local_trip: assert property (p_local_trip)
      else $error("local trip bit wrong");

   property p_remote1_trip;
      trips.remote1Trip && !swReset_q |=> thermalStatus_q[`TFS_TH_REMOTE1];
   endproperty
   a_remote1_trip: assert property (p_remote1_trip)
      else $error("remote 1 trip bit not set");

   property p_remote2_trip;
      !trips.remote2Trip |=> !thermalStatus_q[`TFS_TH_REMOTE2];
   endproperty
   a_remote2_trip: assert property (p_remote2_trip)
      else $error("remote 2 trip bit set without trip");

   property p_duty_set;
      overtempDutyExceeded && !swReset_q |=> thermalStatus_q[`TFS_TH_DUTY];
   endproperty
   a_duty_set: assert property (p_duty_set)
      else $error("duty excess bit not set");

   property p_duty_clear;
      rdThermal && !overtempDutyExceeded |=> !thermalStatus_q[`TFS_TH_DUTY];
   endproperty
   a_duty_clear: assert property (p_duty_clear)
      else $error("duty excess bit not cleared by read");

   property p_duty_zero;
      overtempDutyLimit_q == 8'h00 && overtempActive && !swReset_q
         ##1 !swReset_q |-> ##1 thermalStatus_q[`TFS_TH_DUTY];
   endproperty
   a_duty_zero: assert property (p_duty_zero)
      else $error("zero limit did not reassert duty bit");

   property p_input_flag;
      !swReset_q |=> thermalStatus_q[`TFS_TH_INPUT] ==
                     ($past(!pinSync_q) && !$past(overtempPinOe) &&
                      !$past(overtempPinOe, 2) && !$past(overtempPinOe, 3));
   endproperty
   a_input_flag: assert property (p_input_flag)
      else $error("input asserted bit wrong");

   property p_input_excl;
      thermalStatus_q[`TFS_TH_INPUT] |-> !thermalStatus_q[`TFS_TH_DRIVEN];
   endproperty
   a_input_excl: assert property (p_input_excl)
      else $error("input asserted bit set while driving");

   property p_pin_out;
      overtempPinOut == 1'b0;
   endproperty
   a_pin_out: assert property (p_pin_out)
      else $error("pin output level not low");

   property p_driven_flag;
      $rose(overtempPinOe) && !swReset_q |=> thermalStatus_q[`TFS_TH_DRIVEN];
   endproperty
   a_driven_flag: assert property (p_driven_flag)
      else $error("driven bit not set");

   property p_fan_bits;
      !swReset_q |=> fanAlertStatus_q[`TFS_FAN_STALL1] == $past(fanState.fan1Stall)
                     && fanAlertStatus_q[`TFS_FAN_STALL2] == $past(fanState.fan2Stall);
   endproperty
   a_fan_bits: assert property (p_fan_bits)
      else $error("fan stall bits wrong");

   property p_alarm_speed;
      fanState.alarmSpeed [*2] ##0 !swReset_q |=> fanAlertStatus_q[`TFS_FAN_ALARM];
   endproperty
   a_alarm_speed: assert property (p_alarm_speed)
      else $error("alarm speed bit not set");

   property p_alert_low;
      !swReset_q |=> fanAlertStatus_q[`TFS_FAN_ALERT] == $past(fanState.alertLow);
   endproperty
   a_alert_low: assert property (p_alert_low)
      else $error("alert bit wrong");

   property p_sw_reset;
      swReset_q |=> thermalStatus_q == 8'h00 && fanAlertStatus_q == 8'h00;
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("software reset did not clear status");

   property p_reserved;
      thermalStatus_q[1:0] == 2'b00 && fanAlertStatus_q[4:1] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved status bit set");

   property p_write_ignored;
      wrDone && regIdx == `TFS_IDX_THERMAL && !thermalStatus_q[`TFS_TH_DUTY] &&
         !overtempDutyExceeded |=> !thermalStatus_q[`TFS_TH_DUTY];
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("write to status changed duty bit");

   property p_answer;
      psel && penable && !pready |=> pready;
   endproperty
   a_answer: assert property (p_answer)
      else $error("no answer one cycle into access");

   c_duty_read: cover property (thermalStatus_q[`TFS_TH_DUTY] ##1 rdThermal);
   c_zero_limit: cover property (overtempDutyLimit_q == 8'h00 && overtempActive);
   c_unmapped: cover property (pready && pslverr);
   c_sw_reset: cover property (swReset_q);

endmodule : tfs_status_regs

// file: verification/tb_top.sv
// self-checking bench for the thermal and fan status register bank
`timescale 1ns/1ps
`include "tfs_consts.svh"

module tb_top;
   localparam logic [11:0] ADR_TH = {`TFS_IDX_THERMAL, 2'b00};
   localparam logic [11:0] ADR_FAN = {`TFS_IDX_FAN, 2'b00};
   localparam logic [11:0] ADR_LIM = {`TFS_IDX_LIMIT, 2'b00};
   localparam logic [11:0] ADR_CTL = {`TFS_IDX_CTRL, 2'b00};
   localparam logic [11:0] ADR_ONT = {`TFS_IDX_ONTIME, 2'b00};

   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   tfs_pkg::tfs_trip_t trips = 3'h0;
   tfs_pkg::tfs_fan_t fanState = 4'h0;
   logic driveReq = 1'b0;
   logic extLow = 1'b0;
   logic pinIn;
   logic pinOe;
   logic pinOut;
   logic [7:0] lfsr = 8'h4C;
   int numErrors = 0;
   int totalChecks = 0;
   logic [33:0] expQ[$];

   always #4 clk = ~clk;

   // open-drain pin with pull-up: low when either side pulls
   assign pinIn = ~((pinOe & ~pinOut) | extLow);

   tfs_status_regs #(.ADDR_W(12), .SLOT_CYC(2)) dut (
      .clk(clk),
      .sys_rst(sysRst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .trips(trips),
      .fanState(fanState),
      .overtempDriveReq(driveReq),
      .overtempPinIn(pinIn),
      .overtempPinOut(pinOut),
      .overtempPinOe(pinOe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      totalChecks++;
      if (seen !== want) begin
         numErrors++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // one apb transfer; expectation queued for the watcher
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [31:0] ex, input logic er);
      int n;
      n = 0;
      expQ.push_back({~wr, er, ex});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk("pready", 32'h0, 32'h1);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0, ex, 1'b0);
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin : watch
      logic [33:0] e;
      if (psel && penable && pready === 1'b1) begin
         e = expQ.pop_front();
         chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) begin
            chk("prdata", prdata, e[31:0]);
         end
      end
   end

   initial begin : watchdog
      repeat (20000) @(posedge clk);
      numErrors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin : main
      cyc(8);
      sysRst <= 1'b0;
      rd(ADR_TH, 32'h0);
      rd(ADR_FAN, 32'h0);
      rd(ADR_LIM, 32'h0);
      rd(ADR_CTL, 32'h0);
      rd(ADR_ONT, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         trips <= lfsr[7:5];
         fanState <= lfsr[3:0];
         cyc(2);
         rd(ADR_TH, {24'h0, lfsr[7:5], 5'h00});
         rd(ADR_FAN, {24'h0, lfsr[3], lfsr[1], lfsr[2], 4'h0, lfsr[0]});
      end
      trips <= 3'h0;
      fanState <= 4'h9;
      wr(ADR_TH, 32'hFF);
      wr(ADR_FAN, 32'hFF);
      rd(ADR_TH, 32'h0);
      rd(ADR_FAN, 32'h81);
      apb(1'b1, 12'h200, 32'hFF, 32'h0, 1'b1);
      apb(1'b0, 12'h200, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 12'h141, 32'h0, 32'h0, 1'b1);
      $display("test live bits and refusals done");
      // high limit keeps the duty flag quiet while the pin is exercised
      wr(ADR_LIM, 32'hFF);
      rd(ADR_LIM, 32'hFF);
      driveReq <= 1'b1;
      cyc(4);
      chk("pinOe", {31'h0, pinOe}, 32'h1);
      chk("pinOut", {31'h0, pinOut}, 32'h0);
      rd(ADR_TH, 32'h04);
      driveReq <= 1'b0;
      wr(ADR_CTL, 32'h2);
      cyc(4);
      rd(ADR_TH, 32'h04);
      rd(ADR_CTL, 32'h02);
      wr(ADR_CTL, 32'h0);
      cyc(4);
      rd(ADR_TH, 32'h0);
      extLow <= 1'b1;
      cyc(4);
      chk("pinOe", {31'h0, pinOe}, 32'h0);
      rd(ADR_TH, 32'h08);
      extLow <= 1'b0;
      cyc(4);
      rd(ADR_TH, 32'h0);
      $display("test pin state done");
      wr(ADR_LIM, 32'h10);
      cyc(600);
      rd(ADR_TH, 32'h0);
      extLow <= 1'b1;
      cyc(100);
      extLow <= 1'b0;
      cyc(10);
      wr(ADR_LIM, 32'hFF);
      rd(ADR_TH, 32'h10);
      rd(ADR_TH, 32'h0);
      wr(ADR_LIM, 32'h0);
      extLow <= 1'b1;
      cyc(10);
      rd(ADR_TH, 32'h18);
      rd(ADR_TH, 32'h18);
      $display("test duty excess done");
      extLow <= 1'b0;
      wr(ADR_LIM, 32'hFF);
      cyc(10);
      wr(ADR_CTL, 32'h1);
      cyc(2);
      rd(ADR_TH, 32'h0);
      rd(ADR_LIM, 32'h0);
      rd(ADR_CTL, 32'h0);
      rd(ADR_FAN, 32'h81);
      $display("test software reset done");
      close_out();
   end
endmodule : tb_top
